// *** hw/sdd_pkg.sv ***
// Package: constants, types and register map of the step and direction input decoder
`default_nettype none
package sdd_pkg;
    // Avalon-MM register word offsets (byte address = 4 * index)
    localparam logic [3:0] SDD_REG_CTRL   = 4'h0;
    localparam logic [3:0] SDD_REG_STATUS = 4'h1;
    localparam logic [3:0] SDD_REG_POS    = 4'h2;
    localparam logic [3:0] SDD_REG_COUNT  = 4'h3;

    // Control field positions
    localparam int SDD_CTRL_MODE_BIT  = 0;
    localparam int SDD_CTRL_EDGE_BIT  = 1;
    localparam int SDD_CTRL_CWPOL_BIT = 2;
    localparam int SDD_CTRL_CCWPOL_BIT = 3;
    localparam int SDD_CTRL_DIRINV_BIT = 4;

    // Control value after reset: strobe-plus-heading mode, rising edge, active-high strobes
    localparam logic [31:0] SDD_CTRL_RESET = 32'h0000_000C;

    // Unmapped reads return this value
    localparam logic [31:0] SDD_UNMAPPED_DATA = 32'h0000_0000;

    // Synchroniser depth on pin inputs
    localparam int SDD_SYNC_STAGES = 2;

    // Controller-side timing, in ns, and derived cycles at 100 MHz
    localparam int SDD_CLK_PERIOD_NS      = 10;
    localparam int SDD_MIN_PULSE_NS       = 7500;
    localparam int SDD_HEADING_SETUP_NS   = 5000;
    localparam int SDD_MIN_PULSE_CYC      =
        (SDD_MIN_PULSE_NS + SDD_CLK_PERIOD_NS - 1) / SDD_CLK_PERIOD_NS;
    localparam int SDD_HEADING_SETUP_CYC  =
        (SDD_HEADING_SETUP_NS + SDD_CLK_PERIOD_NS - 1) / SDD_CLK_PERIOD_NS;

    typedef struct packed {
        logic ccw_pol;
        logic cw_pol;
        logic fall_edge;
        logic two_strobe;
    } sdd_cfg_t;

    typedef struct packed {
        logic step;
        logic dir_ccw;
    } sdd_step_t;
endpackage
`default_nettype wire

// *** hw/sdd_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module sdd_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_reset_n,
    // Asynchronous pins and synchronised copy
    input  wire logic [WIDTH-1:0] i_async,
    input  wire logic [WIDTH-1:0] i_rst_val,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // An empty group is refused when the design is elaborated
    if (WIDTH < 1) begin : g_width_check
        $error("sdd_sync: WIDTH must be at least 1");
    end

    // Both stages clear on reset: the async branch takes constants only
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

    logic unused_rst;
    assign unused_rst = |i_rst_val;
endmodule
`default_nettype wire

// *** hw/sdd_decoder.sv ***
// Top: step and direction input decoder with Avalon-MM control registers
// Notes on behaviour
// - In strobe-plus-heading mode one step is taken per rising or falling strobe edge, as set.
// - In strobe-plus-heading mode the heading line level selects one of the two directions.
// - In two-strobe mode the strobe line carries clockwise steps with selectable active level.
// - In two-strobe mode the heading line carries counter-clockwise steps, selectable level.
// - The driver is enabled while the permit line is high; an open permit line reads high.
// - After reset the mode is strobe-plus-heading with the rising edge active.
`default_nettype none
module sdd_decoder
    import sdd_pkg::*;
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Controller pins
    input  wire logic        i_step_strobe_in,
    input  wire logic        i_heading_in,
    input  wire logic        i_drive_permit_in,
    // Avalon-MM slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Motion outputs
    output logic             o_step,
    output logic             o_dir_ccw,
    output logic             o_enabled
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [2:0] pins_sync;
    logic       strobe_s;
    logic       heading_s;
    logic       permit_s;
    logic [2:0] pins_prev_r;

    sdd_sync #(
        .WIDTH (3)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    ({i_drive_permit_in, i_heading_in, i_step_strobe_in}),
        .i_rst_val  (3'h0),
        .o_sync     (pins_sync)
    );

    assign strobe_s  = pins_sync[0];
    assign heading_s = pins_sync[1];
    // Pin has a pull-up outside, so an open input is read as high
    assign permit_s  = pins_sync[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration register
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    sdd_cfg_t    cfg;
    logic        dir_inv;

    assign cfg.two_strobe = ctrl_r[SDD_CTRL_MODE_BIT];
    assign cfg.fall_edge  = ctrl_r[SDD_CTRL_EDGE_BIT];
    assign cfg.cw_pol     = ctrl_r[SDD_CTRL_CWPOL_BIT];
    assign cfg.ccw_pol    = ctrl_r[SDD_CTRL_CCWPOL_BIT];
    assign dir_inv        = ctrl_r[SDD_CTRL_DIRINV_BIT];

    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    logic wr_ctrl;
    logic wr_count;
    assign wr_ctrl  = i_avs_write && (i_avs_address == SDD_REG_CTRL);
    assign wr_count = i_avs_write && (i_avs_address == SDD_REG_COUNT);
    assign ctrl_nxt = wr_ctrl ?
        (merge_be(ctrl_r, i_avs_writedata, i_avs_byteenable) & 32'h0000_001F) : ctrl_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Event detection
    logic strobe_prev;
    logic heading_prev;
    logic permit_prev;
    logic strobe_rise;
    logic strobe_fall;
    logic cw_act;
    logic ccw_act;
    logic cw_prev_act;
    logic ccw_prev_act;
    logic pd_event;
    logic cw_event;
    logic ccw_event;
    sdd_step_t step_nxt;

    assign strobe_prev  = pins_prev_r[0];
    assign heading_prev = pins_prev_r[1];
    assign permit_prev  = pins_prev_r[2];
    assign strobe_rise  = strobe_s && !strobe_prev;
    assign strobe_fall  = !strobe_s && strobe_prev;
    assign pd_event     = cfg.fall_edge ? strobe_fall : strobe_rise;
    // Onset of the active level counts once per pulse, not once per cycle
    assign cw_act       = (strobe_s == cfg.cw_pol);
    assign ccw_act      = (heading_s == cfg.ccw_pol);
    assign cw_prev_act  = (strobe_prev == cfg.cw_pol);
    assign ccw_prev_act = (heading_prev == cfg.ccw_pol);
    assign cw_event     = cw_act && !cw_prev_act;
    assign ccw_event    = ccw_act && !ccw_prev_act;

    // Permit sampled also on the previous cycle so an edge coinciding with re-enable is dropped
    logic permit_ok;
    assign permit_ok = permit_s && permit_prev;

    always_comb begin
        step_nxt = '0;
        if (!cfg.two_strobe) begin
            step_nxt.step    = pd_event && permit_ok;
            step_nxt.dir_ccw = heading_s ^ dir_inv;
        end else if (cw_event != ccw_event) begin
            // Both strobes starting together cancel: no net motion is taken
            step_nxt.step    = permit_ok;
            step_nxt.dir_ccw = ccw_event;
        end else begin
            step_nxt.step    = 1'b0;
            step_nxt.dir_ccw = o_dir_ccw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Position and step count
    logic [31:0] pos_r;
    logic [31:0] pos_nxt;
    logic [31:0] count_r;
    logic [31:0] count_nxt;

    assign pos_nxt   = !o_step ? pos_r :
                       (o_dir_ccw ? pos_r - 32'h0000_0001 : pos_r + 32'h0000_0001);
    // Counter write loses to nothing: the step is added on top of the written value
    assign count_nxt = (wr_count ? merge_be(count_r, i_avs_writedata, i_avs_byteenable)
                                 : count_r) + {31'h0, o_step};

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_r <= SDD_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Previous synced levels feed the edge and onset detectors
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pins_prev_r <= 3'h0;
        end else begin
            pins_prev_r <= pins_sync;
        end
    end

    // Step and heading leave flip-flops so the motor side sees clean levels
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_step    <= 1'b0;
            o_dir_ccw <= 1'b0;
            o_enabled <= 1'b0;
        end else begin
            o_step    <= step_nxt.step;
            o_dir_ccw <= step_nxt.dir_ccw;
            o_enabled <= permit_s;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pos_r <= 32'h0000_0000;
        end else begin
            pos_r <= pos_nxt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_r <= 32'h0000_0000;
        end else begin
            count_r <= count_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon-MM read path: one wait state so that read data leave a flip-flop
    logic [31:0] rd_mux;
    logic [31:0] rdata_r;
    logic        rd_done_r;
    logic        rd_load;

    // First read cycle captures the word and stalls, the second releases the master
    assign rd_load           = i_avs_read && !rd_done_r;
    assign o_avs_waitrequest = rd_load;
    assign rd_mux =
        (i_avs_address == SDD_REG_CTRL)   ? ctrl_r :
        (i_avs_address == SDD_REG_STATUS) ? {28'h0, o_dir_ccw, permit_s, heading_s, strobe_s} :
        (i_avs_address == SDD_REG_POS)    ? pos_r :
        (i_avs_address == SDD_REG_COUNT)  ? count_r : SDD_UNMAPPED_DATA;
    assign o_avs_readdata    = rdata_r;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r   <= SDD_UNMAPPED_DATA;
            rd_done_r <= 1'b0;
        end else begin
            rdata_r   <= rd_load ? rd_mux : rdata_r;
            rd_done_r <= rd_load;
        end
    end
endmodule
`default_nettype wire

// *** verification/sdd_decoder_properties.sv ***
// Port-level properties of the step and heading decoder
`default_nettype none
module sdd_props
    import sdd_pkg::*;
(
    // Watched ports
    input wire logic        i_core_clk,
    input wire logic        i_reset_n,
    input wire logic        i_step_strobe_in,
    input wire logic        i_heading_in,
    input wire logic        i_drive_permit_in,
    input wire logic [3:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_step,
    input wire logic        o_dir_ccw,
    input wire logic        o_enabled
);
    logic [4:0] cfg_r;
    // Shadow of the control bits, so mode checks need no internal probes
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_r <= SDD_CTRL_RESET[4:0];
        end else if (i_avs_write && i_avs_address == SDD_REG_CTRL && i_avs_byteenable[0]) begin
            cfg_r <= i_avs_writedata[4:0];
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    AST_CTRL_READ: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address == SDD_REG_CTRL
        |-> o_avs_readdata[4:0] == cfg_r) else $error("ctrl read");
    AST_EDGE_SEL: assert property (o_step && !cfg_r[0]
        |-> $past(i_step_strobe_in, 3) == !cfg_r[1] && $past(i_step_strobe_in, 6) == cfg_r[1])
        else $error("edge");
    AST_HEAD_LEVEL: assert property (o_step && !cfg_r[0]
        |-> o_dir_ccw == ($past(i_heading_in, 3) ^ cfg_r[4])) else $error("heading");
    AST_CW_STROBE: assert property (o_step && cfg_r[0]
        && $past(i_step_strobe_in, 3) == cfg_r[2] && $past(i_step_strobe_in, 6) != cfg_r[2]
        |-> !o_dir_ccw) else $error("cw");
    AST_CCW_STROBE: assert property (o_step && cfg_r[0]
        && $past(i_heading_in, 3) == cfg_r[3] && $past(i_heading_in, 6) != cfg_r[3]
        |-> o_dir_ccw) else $error("ccw");
    AST_PERMIT_HIGH: assert property (i_drive_permit_in [*4] |=> o_enabled) else $error("en");
    AST_PERMIT_LOW: assert property (!i_drive_permit_in [*4] |=> !o_enabled && !o_step)
        else $error("dis");
    AST_ONE_STEP: assert property (o_step |-> o_enabled ##1 !o_step) else $error("step");
    cover property (o_step && !cfg_r[0] && o_dir_ccw);
    cover property (o_step && cfg_r[0] && !cfg_r[2]);
    cover property ($fell(o_enabled));
endmodule
bind sdd_decoder sdd_props i_sdd_props (.i_core_clk, .i_reset_n, .i_step_strobe_in,
    .i_heading_in, .i_drive_permit_in, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_step,
    .o_dir_ccw, .o_enabled);
`default_nettype wire

// *** verification/sdd_ctrl_model.sv ***
// Motion controller model driving strobe, heading and permit pins
`default_nettype none
module sdd_ctrl_model
    import sdd_pkg::*;
(
    // Clock in, pins out
    input  wire logic i_core_clk,
    output var logic  o_strobe,
    output var logic  o_heading,
    output var logic  o_permit
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {o_strobe, o_heading, o_permit} = 3'h1;
    // Levels at once, then room for the synchronisers
    task automatic set(input logic [2:0] v);
        {o_strobe, o_heading, o_permit} <= v;
        repeat (8) @(posedge i_core_clk);
    endtask
    task automatic head(input logic h);
        o_heading <= h;
        repeat (SDD_HEADING_SETUP_CYC + 1) @(posedge i_core_clk);
    endtask
    // Active and rest spans each just past the minimum, the slowest legal rate is not needed
    task automatic pulse(input logic line, input logic act);
        {o_heading, o_strobe} <= line ? {act, o_strobe} : {o_heading, act};
        repeat (SDD_MIN_PULSE_CYC + 1) @(posedge i_core_clk);
        {o_heading, o_strobe} <= line ? {!act, o_strobe} : {o_heading, !act};
        repeat (SDD_MIN_PULSE_CYC + 1) @(posedge i_core_clk);
    endtask
endmodule
`default_nettype wire

// *** verification/tb_sdd_decoder.sv ***
// Bench: decoder against a step counting model
`default_nettype none
module tb_sdd_decoder
    import sdd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, stb, hd, pm, step, dir, en, wt, lv;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, q;
    logic        ld = 1'b0;
    logic        dq [$];
    logic [31:0] ctab [5] = '{32'h0C, 32'h1E, 32'h0D, 32'h01, 32'h01};
    logic [15:0] rnd = 16'h7FEE;
    int          bad_count = 0, checked = 0, xn = 0, xp = 0, an = 0, ap = 0;
    sdd_decoder i_sdd_decoder (.i_core_clk(clk), .i_reset_n(rst_n), .i_step_strobe_in(stb),
        .i_heading_in(hd), .i_drive_permit_in(pm), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .o_step(step), .o_dir_ccw(dir), .o_enabled(en));
    sdd_ctrl_model i_sdd_ctrl_model (.i_core_clk(clk), .o_strobe(stb), .o_heading(hd),
        .o_permit(pm));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        an += int'(step === 1'b1);
        ap += (step !== 1'b1) ? 0 : (dir ? -1 : 1);
        if (step === 1'b1) begin
            checked++;
            if (dq.size() == 0 || dir !== dq.pop_front()) begin
                bad_count++;
                $display("Error at %0t: step with unexpected heading", $time);
            end
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        {wr, rd, adr, wd} <= {w, !w, a, d};
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        q = rdat;
        {wr, rd} <= 2'h0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, SDD_REG_CTRL, 32'h0);
        chk(q, SDD_CTRL_RESET);
        bus(1'b0, 4'hA, 32'h0);
        chk(q, SDD_UNMAPPED_DATA);
        // Permit drops first so idle-level moves are never taken as steps
        for (int m = 0; m < 5; m++) begin
            lv = m == 1 || m > 2;
            i_sdd_ctrl_model.set({stb, hd, 1'b0});
            i_sdd_ctrl_model.set({lv, m > 2, 1'b0});
            bus(1'b1, SDD_REG_CTRL, ctab[m]);
            i_sdd_ctrl_model.set({lv, m > 2, m < 4});
            chk(32'(en), 32'(m < 4));
            for (int k = 0; k < 4; k++) begin
                rnd = lfsr(rnd);
                if (m < 2) i_sdd_ctrl_model.head(rnd[0]);
                if (m < 4) begin
                    ld = rnd[0] ^ (m == 1);
                    dq.push_back(ld);
                    xn++;
                    xp += ld ? -1 : 1;
                end
                i_sdd_ctrl_model.pulse(m > 1 && rnd[0], !lv);
                chk(32'(an), 32'(xn));
                chk(32'(ap), 32'(xp));
            end
            bus(1'b0, SDD_REG_POS, 32'h0);
            chk(q, 32'(xp));
        end
        bus(1'b0, SDD_REG_STATUS, 32'h0);
        chk(q, {28'h0, ld, 3'h3});
        bus(1'b0, SDD_REG_COUNT, 32'h0);
        chk(q, 32'(xn));
        bus(1'b1, SDD_REG_COUNT, 32'h0000_1234);
        bus(1'b0, SDD_REG_COUNT, 32'h0);
        chk(q, 32'h0000_1234);
        chk(32'(dq.size()), 32'h0);
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
